// ---- hdl/ips_pin_select.sv ----
// Function select of the two I2C-capable pins with its Wishbone register file
// Function
// - Clock-pin low nibble selects its function
// - Data-pin nibble same, code 4 data line
// - Bit six enables analog readings
// - Bit seven enables internal pull-up
// - Function zero ignores byte, applies fallback
// - Clock default, analog mode: drive high
// - Clock default, otherwise: I2C clock, pull-up
// - Data default, analog mode: analog user input
// - Data default, otherwise: I2C data, pull-up
`timescale 1ns/1ps
module ips_pin_select
	import ips_pkg::*;
(
	input  wire logic              CLK_SYS,
	input  wire logic              RST_N,
	input  wire logic [ADR_W-1:0]  WB_ADR_I,
	input  wire logic [DATA_W-1:0] WB_DAT_I,
	input  wire logic [3:0]        WB_SEL_I,
	input  wire logic              WB_WE_I,
	input  wire logic              WB_CYC_I,
	input  wire logic              WB_STB_I,
	output logic [DATA_W-1:0]      WB_DAT_O,
	output logic                   WB_ACK_O,
	input  wire logic              CLKPIN_I,
	output logic                   CLKPIN_O,
	output logic                   CLKPIN_OE,
	output logic                   CLKPIN_PU,
	output logic                   CLKPIN_AN,
	input  wire logic              DATPIN_I,
	output logic                   DATPIN_O,
	output logic                   DATPIN_OE,
	output logic                   DATPIN_PU,
	output logic                   DATPIN_AN,
	input  wire logic              I2C_CLK_LOW,
	input  wire logic              I2C_DAT_LOW,
	output logic                   I2C_CLK_IN,
	output logic                   I2C_DAT_IN,
	output logic                   KILL_SW,
	output logic                   LIMIT_FWD,
	output logic                   LIMIT_REV
);
	typedef struct packed {
		logic [7:0]        clk_cfg;
		logic [7:0]        dat_cfg;
		logic [7:0]        mode;
		logic [3:0]        user;
		logic              ack;
		logic [DATA_W-1:0] rdata;
		logic              clk_o;
		logic              clk_oe;
		logic              clk_pu;
		logic              clk_an;
		logic              dat_o;
		logic              dat_oe;
		logic              dat_pu;
		logic              dat_an;
		logic              i2c_clk_in;
		logic              i2c_dat_in;
		logic              kill;
		logic              lim_fwd;
		logic              lim_rev;
	} ips_state_s;

	ips_state_s s_q;
	ips_state_s s_d;

	ips_role_e  clk_role;
	ips_role_e  dat_role;
	logic       clk_pu;
	logic       clk_an;
	logic       dat_pu;
	logic       dat_an;
	logic       clk_o;
	logic       clk_oe;
	logic       dat_o;
	logic       dat_oe;
	logic       req;
	logic       analog_mode;

	assign analog_mode = s_q.mode[MODE_ANALOG];
	// One cycle per access: a new request is only seen once the previous ack has gone
	assign req         = WB_CYC_I & WB_STB_I & ~s_q.ack;

	ips_pin_decode #(
		.HAS_POT     (1'b1)
	) u_clk_decode (
		.cfg         (s_q.clk_cfg),
		.analog_mode (analog_mode),
		.role        (clk_role),
		.pull_en     (clk_pu),
		.analog_en   (clk_an)
	);

	ips_pin_decode #(
		.HAS_POT     (1'b0)
	) u_dat_decode (
		.cfg         (s_q.dat_cfg),
		.analog_mode (analog_mode),
		.role        (dat_role),
		.pull_en     (dat_pu),
		.analog_en   (dat_an)
	);

	ips_pin_drive u_clk_drive (
		.role    (clk_role),
		.usr_val (s_q.user[USR_CLK_VAL]),
		.usr_drv (s_q.user[USR_CLK_DRV]),
		.i2c_low (I2C_CLK_LOW),
		.pin_o   (clk_o),
		.pin_oe  (clk_oe)
	);

	ips_pin_drive u_dat_drive (
		.role    (dat_role),
		.usr_val (s_q.user[USR_DAT_VAL]),
		.usr_drv (s_q.user[USR_DAT_DRV]),
		.i2c_low (I2C_DAT_LOW),
		.pin_o   (dat_o),
		.pin_oe  (dat_oe)
	);

	// Switch inputs read active high; both pins may carry the same switch
	function automatic logic role_hit(
		input ips_role_e r0,
		input logic      l0,
		input ips_role_e r1,
		input logic      l1,
		input ips_role_e want
	);
		return ((r0 == want) & l0) | ((r1 == want) & l1);
	endfunction

	function automatic logic [DATA_W-1:0] status_word(
		input ips_role_e cr,
		input ips_role_e dr,
		input logic      cl,
		input logic      dl,
		input logic      cp,
		input logic      ca,
		input logic      dp,
		input logic      da
	);
		logic [DATA_W-1:0] w;
		w                       = '0;
		w[ST_CLK_ROLE +: 3]     = cr;
		w[ST_DAT_ROLE +: 3]     = dr;
		w[ST_CLK_LVL]           = cl;
		w[ST_DAT_LVL]           = dl;
		w[ST_CLK_PU]            = cp;
		w[ST_CLK_AN]            = ca;
		w[ST_DAT_PU]            = dp;
		w[ST_DAT_AN]            = da;
		return w;
	endfunction

	always_comb
	begin
		s_d       = s_q;
		s_d.ack   = req;
		s_d.rdata = s_q.rdata;

		if (req)
		begin
			s_d.rdata = '0;
			if (WB_ADR_I == ips_byte_addr(IDX_CLK_CFG))
			begin
				s_d.rdata[7:0] = s_q.clk_cfg;
				// Reserved bits are stored as written; keeping them zero is up to software
				if (WB_WE_I && WB_SEL_I[0])
					s_d.clk_cfg = WB_DAT_I[7:0];
			end
			else if (WB_ADR_I == ips_byte_addr(IDX_DAT_CFG))
			begin
				s_d.rdata[7:0] = s_q.dat_cfg;
				if (WB_WE_I && WB_SEL_I[0])
					s_d.dat_cfg = WB_DAT_I[7:0];
			end
			else if (WB_ADR_I == ips_byte_addr(IDX_MODE))
			begin
				s_d.rdata[7:0] = s_q.mode;
				if (WB_WE_I && WB_SEL_I[0])
					s_d.mode = WB_DAT_I[7:0];
			end
			else if (WB_ADR_I == ips_byte_addr(IDX_USER))
			begin
				s_d.rdata[3:0] = s_q.user;
				if (WB_WE_I && WB_SEL_I[0])
					s_d.user = WB_DAT_I[3:0];
			end
			else if (WB_ADR_I == ips_byte_addr(IDX_STATUS))
			begin
				s_d.rdata = status_word(clk_role, dat_role, CLKPIN_I, DATPIN_I,
					clk_pu, clk_an, dat_pu, dat_an);
			end
			else
			begin
				s_d.rdata = '0;
			end
		end

		s_d.clk_o      = clk_o;
		s_d.clk_oe     = clk_oe;
		s_d.clk_pu     = clk_pu;
		s_d.clk_an     = clk_an;
		s_d.dat_o      = dat_o;
		s_d.dat_oe     = dat_oe;
		s_d.dat_pu     = dat_pu;
		s_d.dat_an     = dat_an;

		// The I2C engine sees an idle-high line unless the pin really serves it
		s_d.i2c_clk_in = (clk_role == ROLE_I2C) ? CLKPIN_I : 1'b1;
		s_d.i2c_dat_in = (dat_role == ROLE_I2C) ? DATPIN_I : 1'b1;

		s_d.kill    = role_hit(clk_role, CLKPIN_I, dat_role, DATPIN_I, ROLE_KILL);
		s_d.lim_fwd = role_hit(clk_role, CLKPIN_I, dat_role, DATPIN_I, ROLE_LIM_FWD);
		s_d.lim_rev = role_hit(clk_role, CLKPIN_I, dat_role, DATPIN_I, ROLE_LIM_REV);
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			s_q            <= '0;
			s_q.clk_cfg    <= CFG_RST;
			s_q.dat_cfg    <= CFG_RST;
			s_q.mode       <= MODE_RST;
			s_q.user       <= USER_RST;
			s_q.i2c_clk_in <= 1'b1;
			s_q.i2c_dat_in <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign WB_DAT_O   = s_q.rdata;
	assign WB_ACK_O   = s_q.ack;
	assign CLKPIN_O   = s_q.clk_o;
	assign CLKPIN_OE  = s_q.clk_oe;
	assign CLKPIN_PU  = s_q.clk_pu;
	assign CLKPIN_AN  = s_q.clk_an;
	assign DATPIN_O   = s_q.dat_o;
	assign DATPIN_OE  = s_q.dat_oe;
	assign DATPIN_PU  = s_q.dat_pu;
	assign DATPIN_AN  = s_q.dat_an;
	assign I2C_CLK_IN = s_q.i2c_clk_in;
	assign I2C_DAT_IN = s_q.i2c_dat_in;
	assign KILL_SW    = s_q.kill;
	assign LIMIT_FWD  = s_q.lim_fwd;
	assign LIMIT_REV  = s_q.lim_rev;
endmodule

// ---- hdl/ips_pkg.sv ----
// Register map, field layout, reset values and function codes of the pin select block
package ips_pkg;
	localparam int unsigned DATA_W         = 32;
	localparam int unsigned ADR_W          = 12;
	localparam logic [7:0]  IDX_CLK_CFG    = 8'h3B;
	localparam logic [7:0]  IDX_DAT_CFG    = 8'h3C;
	localparam logic [7:0]  IDX_MODE       = 8'h40;
	localparam logic [7:0]  IDX_USER       = 8'h41;
	localparam logic [7:0]  IDX_STATUS     = 8'h42;
	localparam int unsigned FN_LSB         = 0;
	localparam int unsigned FN_W           = 4;
	localparam int unsigned RSV_LSB        = 4;
	localparam int unsigned ANALOG_BIT     = 6;
	localparam int unsigned PULLUP_BIT     = 7;
	localparam logic [7:0]  CFG_RST        = 8'h00;
	localparam logic [7:0]  MODE_RST       = 8'h00;
	localparam logic [3:0]  USER_RST       = 4'h0;
	localparam int unsigned MODE_ANALOG    = 0;
	localparam int unsigned USR_CLK_VAL    = 0;
	localparam int unsigned USR_CLK_DRV    = 1;
	localparam int unsigned USR_DAT_VAL    = 2;
	localparam int unsigned USR_DAT_DRV    = 3;
	localparam int unsigned ST_CLK_ROLE    = 0;
	localparam int unsigned ST_DAT_ROLE    = 4;
	localparam int unsigned ST_CLK_LVL     = 8;
	localparam int unsigned ST_DAT_LVL     = 9;
	localparam int unsigned ST_CLK_PU      = 10;
	localparam int unsigned ST_CLK_AN      = 11;
	localparam int unsigned ST_DAT_PU      = 12;
	localparam int unsigned ST_DAT_AN      = 13;

	typedef enum logic [3:0] {
		FN_DEFAULT = 4'h0,
		FN_USER_IO = 4'h1,
		FN_USER_IN = 4'h2,
		FN_POT_PWR = 4'h3,
		FN_I2C     = 4'h4,
		FN_KILL    = 4'h7,
		FN_LIM_FWD = 4'h8,
		FN_LIM_REV = 4'h9
	} ips_func_e;

	typedef enum logic [2:0] {
		ROLE_HIZ     = 3'h0,
		ROLE_USER_IO = 3'h1,
		ROLE_USER_IN = 3'h2,
		ROLE_POT_PWR = 3'h3,
		ROLE_I2C     = 3'h4,
		ROLE_KILL    = 3'h5,
		ROLE_LIM_FWD = 3'h6,
		ROLE_LIM_REV = 3'h7
	} ips_role_e;

	function automatic logic [ADR_W-1:0] ips_byte_addr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction
endpackage

// ---- hdl/ips_pin_decode.sv ----
// Resolves one pin configuration byte into the pin's effective role and options
`timescale 1ns/1ps
module ips_pin_decode
	import ips_pkg::*;
#(
	parameter bit HAS_POT = 1'b1
)
(
	input  wire logic [7:0] cfg,
	input  wire logic       analog_mode,
	output ips_role_e       role,
	output logic            pull_en,
	output logic            analog_en
);
	always_comb
	begin
		role      = ROLE_HIZ;
		pull_en   = cfg[PULLUP_BIT];
		analog_en = cfg[ANALOG_BIT];
		// Bits 5:4 never reach the decode
		case (cfg[FN_LSB +: FN_W])
			FN_DEFAULT:
			begin
				pull_en   = 1'b0;
				analog_en = 1'b0;
				if (analog_mode)
				begin
					if (HAS_POT)
						role = ROLE_POT_PWR;
					else
					begin
						role      = ROLE_USER_IN;
						analog_en = 1'b1;
					end
				end
				else
				begin
					role    = ROLE_I2C;
					pull_en = 1'b1;
				end
			end
			FN_USER_IO: role = ROLE_USER_IO;
			FN_USER_IN: role = ROLE_USER_IN;
			FN_POT_PWR: role = HAS_POT ? ROLE_POT_PWR : ROLE_HIZ;
			FN_I2C:     role = ROLE_I2C;
			FN_KILL:    role = ROLE_KILL;
			FN_LIM_FWD: role = ROLE_LIM_FWD;
			FN_LIM_REV: role = ROLE_LIM_REV;
			default:    role = ROLE_HIZ;
		endcase
		// An unusable code must not leave a pull-up or analog path hanging on the pin
		if (role == ROLE_HIZ)
		begin
			pull_en   = 1'b0;
			analog_en = 1'b0;
		end
	end
endmodule

// ---- hdl/ips_pin_drive.sv ----
// Output value and enable of one pin for its resolved role
`timescale 1ns/1ps
module ips_pin_drive
	import ips_pkg::*;
(
	input  ips_role_e  role,
	input  wire logic  usr_val,
	input  wire logic  usr_drv,
	input  wire logic  i2c_low,
	output logic       pin_o,
	output logic       pin_oe
);
	always_comb
	begin
		pin_o  = 1'b0;
		pin_oe = 1'b0;
		case (role)
			ROLE_USER_IO:
			begin
				pin_o  = usr_val;
				pin_oe = usr_drv;
			end
			ROLE_POT_PWR:
			begin
				pin_o  = 1'b1;
				pin_oe = 1'b1;
			end
			// Open drain: only ever pulls low, the pull-up gives the high level
			ROLE_I2C:
			begin
				pin_o  = 1'b0;
				pin_oe = i2c_low;
			end
			default:
			begin
				pin_o  = 1'b0;
				pin_oe = 1'b0;
			end
		endcase
	end
endmodule

// ---- dv/ips_pin_select_assertions.sv ----
// Checker of pin outputs against a shadow of the bus-written configuration
`timescale 1ns/1ps
module ips_pin_select_chk
	import ips_pkg::*;
(
	input wire logic              CLK_SYS,
	input wire logic              RST_N,
	input wire logic [ADR_W-1:0]  WB_ADR_I,
	input wire logic [DATA_W-1:0] WB_DAT_I,
	input wire logic [3:0]        WB_SEL_I,
	input wire logic              WB_WE_I,
	input wire logic              WB_CYC_I,
	input wire logic              WB_STB_I,
	input wire logic              WB_ACK_O,
	input wire logic              CLKPIN_I,
	input wire logic              DATPIN_I,
	input wire logic              I2C_CLK_LOW,
	input wire logic              I2C_DAT_LOW,
	input wire logic              CLKPIN_O,
	input wire logic              CLKPIN_OE,
	input wire logic              CLKPIN_PU,
	input wire logic              CLKPIN_AN,
	input wire logic              DATPIN_OE,
	input wire logic              DATPIN_PU,
	input wire logic              DATPIN_AN,
	input wire logic              I2C_DAT_IN,
	input wire logic              KILL_SW
);
	logic [7:0] cfg_c_q;
	logic [7:0] cfg_d_q;
	logic       mode_q;
	wire logic  wr = WB_CYC_I & WB_STB_I & ~WB_ACK_O & WB_WE_I & WB_SEL_I[0];
	wire logic  cv = cfg_c_q[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9};
	wire logic  dbad = !(cfg_d_q[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'h8, 4'h9});
	// Shadow updates on the taking edge, as the register file does
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			cfg_c_q <= 8'h00;
			cfg_d_q <= 8'h00;
			mode_q  <= 1'b0;
		end
		else if (wr)
		begin
			if (WB_ADR_I == {2'h0, IDX_CLK_CFG, 2'h0})
				cfg_c_q <= WB_DAT_I[7:0];
			if (WB_ADR_I == {2'h0, IDX_DAT_CFG, 2'h0})
				cfg_d_q <= WB_DAT_I[7:0];
			if (WB_ADR_I == {2'h0, IDX_MODE, 2'h0})
				mode_q <= WB_DAT_I[0];
		end
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence s_ack;
		WB_ACK_O ##1 !WB_ACK_O;
	endsequence
	property p_ack;
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
	property p_clk_pot;
		$past(RST_N) && $past(cfg_c_q[3:0]) == 4'h0 && $past(mode_q)
			|-> CLKPIN_O && CLKPIN_OE && !CLKPIN_PU;
	endproperty
	a_clk_pot: assert property (p_clk_pot) else $error("clock pin not driven high");
	property p_clk_i2c;
		$past(RST_N) && $past(cfg_c_q[3:0]) == 4'h0 && !$past(mode_q)
			|-> CLKPIN_PU && !CLKPIN_AN && CLKPIN_OE == $past(I2C_CLK_LOW);
	endproperty
	a_clk_i2c: assert property (p_clk_i2c) else $error("clock pin not i2c");
	property p_dat_an;
		$past(RST_N) && $past(cfg_d_q[3:0]) == 4'h0 && $past(mode_q)
			|-> DATPIN_AN && !DATPIN_PU && !DATPIN_OE;
	endproperty
	a_dat_an: assert property (p_dat_an) else $error("data pin not analog input");
	property p_dat_i2c;
		$past(RST_N) && $past(cfg_d_q[3:0]) == 4'h0 && !$past(mode_q) |-> DATPIN_PU
			&& DATPIN_OE == $past(I2C_DAT_LOW) && I2C_DAT_IN == $past(DATPIN_I);
	endproperty
	a_dat_i2c: assert property (p_dat_i2c) else $error("data pin not i2c");
	property p_opt;
		$past(RST_N) && $past(cv) |-> CLKPIN_PU == $past(cfg_c_q[7])
			&& CLKPIN_AN == $past(cfg_c_q[6]);
	endproperty
	a_opt: assert property (p_opt) else $error("clock pin options wrong");
	property p_def_ign;
		$past(cfg_c_q[3:0]) == 4'h0 && $past(cfg_c_q[6]) |-> !CLKPIN_AN;
	endproperty
	a_def_ign: assert property (p_def_ign) else $error("default kept byte option");
	property p_hiz;
		$past(RST_N) && $past(dbad) |-> !DATPIN_OE && !DATPIN_PU && !DATPIN_AN;
	endproperty
	a_hiz: assert property (p_hiz) else $error("bad code not floating");
	property p_kill;
		$past(RST_N) && $past(cfg_c_q[3:0]) == 4'h7 && $past(CLKPIN_I) |-> KILL_SW;
	endproperty
	a_kill: assert property (p_kill) else $error("kill input not passed");
endmodule

// ---- dv/ips_pin_select_test.sv ----
// Register-driven test of the pin function select
`timescale 1ns/1ps
module ips_pin_select_test
	import ips_pkg::*;
;
	localparam logic [11:0] AC = {2'h0, IDX_CLK_CFG, 2'h0};
	localparam logic [11:0] AD = {2'h0, IDX_DAT_CFG, 2'h0};
	localparam logic [11:0] AM = {2'h0, IDX_MODE, 2'h0};
	localparam logic [11:0] AU = {2'h0, IDX_USER, 2'h0};
	logic        clk_sys, rst_n, cyc, we, ack;
	logic        c_o, c_oe, c_pu, c_an, d_o, d_oe, d_pu, d_an;
	logic        i2c_ci, i2c_di, kill, lfwd, lrev;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [7:0]  cc, dc;
	int          bad_count, n_checks, m, c;
	ips_pin_select dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .CLKPIN_I(1'b1), .CLKPIN_O(c_o), .CLKPIN_OE(c_oe), .CLKPIN_PU(c_pu),
		.CLKPIN_AN(c_an), .DATPIN_I(1'b0), .DATPIN_O(d_o), .DATPIN_OE(d_oe), .DATPIN_PU(d_pu),
		.DATPIN_AN(d_an), .I2C_CLK_LOW(1'b1), .I2C_DAT_LOW(1'b0), .I2C_CLK_IN(i2c_ci),
		.I2C_DAT_IN(i2c_di), .KILL_SW(kill), .LIMIT_FWD(lfwd), .LIMIT_REV(lrev));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		cyc  <= 1'b1;
		adr  <= a;
		we   <= w;
		wdat <= d;
		do @(posedge clk_sys); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
	endtask
	// {driven value, drive enable, pull-up, analog}; user register holds all ones
	function automatic logic [3:0] ex(input logic [3:0] f, input logic dp, md, b7, b6, low);
		case (f)
			4'h0: return md ? (dp ? 4'h1 : 4'hC) : {1'b0, low, 2'h2};
			4'h1: return {2'h3, b7, b6};
			4'h2, 4'h7, 4'h8, 4'h9: return {2'h0, b7, b6};
			4'h3: return dp ? 4'h0 : {2'h3, b7, b6};
			4'h4: return {1'b0, low, b7, b6};
			default: return 4'h0;
		endcase
	endfunction
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		rst_n = 1'b0;
		cyc   = 1'b0;
		we    = 1'b0;
		adr   = 12'h000;
		wdat  = 32'h0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(AC, 1'b0, 32'h0);
		chk(q, 32'h0);
		bus(AD, 1'b0, 32'h0);
		chk(q, 32'h0);
		bus(12'hFFC, 1'b1, 32'hFF);
		bus(12'hFFC, 1'b0, 32'h0);
		chk(q, 32'h0);
		bus(AU, 1'b1, 32'hF);
		for (m = 0; m < 2; m++)
			for (c = 0; c < 16; c++)
			begin
				cc = {4'h4, c[3:0]};
				dc = {4'h8, c[3:0]};
				bus(AC, 1'b1, {24'h0, cc});
				bus(AD, 1'b1, {24'h0, dc});
				bus(AM, 1'b1, m);
				bus(AC, 1'b0, 32'h0);
				chk(q, {24'h0, cc});
				repeat (2) @(posedge clk_sys);
				chk({c_o & c_oe, c_oe, c_pu, c_an}, ex(c[3:0], 1'b0, m[0], 1'b0, 1'b1, 1'b1));
				chk({d_o & d_oe, d_oe, d_pu, d_an}, ex(c[3:0], 1'b1, m[0], 1'b1, 1'b0, 1'b0));
				chk({kill, lfwd, lrev, i2c_ci, i2c_di},
					{c == 7, c == 8, c == 9, 1'b1, !(c == 4 || (c == 0 && m == 0))});
			end
		report_and_stop();
	end
endmodule
bind ips_pin_select ips_pin_select_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .CLKPIN_I(CLKPIN_I),
	.DATPIN_I(DATPIN_I), .I2C_CLK_LOW(I2C_CLK_LOW), .I2C_DAT_LOW(I2C_DAT_LOW),
	.CLKPIN_O(CLKPIN_O), .CLKPIN_OE(CLKPIN_OE), .CLKPIN_PU(CLKPIN_PU), .CLKPIN_AN(CLKPIN_AN),
	.DATPIN_OE(DATPIN_OE), .DATPIN_PU(DATPIN_PU), .DATPIN_AN(DATPIN_AN),
	.I2C_DAT_IN(I2C_DAT_IN), .KILL_SW(KILL_SW));
